// File: logic/ssbc_pkg.sv
// burst sram control: shared constants, state type and burst order function
// assumes one pclk domain, an apb register port and synchronous sram bus pins
package ssbc_pkg;
	localparam int unsigned APB_AW = 12;
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam int unsigned CTRL_SLEEP_POS = 0;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int unsigned STAT_BURST_POS = 0;
	localparam int unsigned STAT_PIPE_POS = 2;
	localparam int unsigned STAT_ILV_POS = 3;
	localparam int unsigned STAT_SLEEP_POS = 4;
	localparam int unsigned STAT_ACTIVE_POS = 5;
	localparam int unsigned STAT_TIE_POS = 6;
	localparam int unsigned PIN_OE = 0;
	localparam int unsigned PIN_SLEEP = 1;
	localparam int unsigned PIN_FLOW = 2;
	localparam int unsigned PIN_ORDER = 3;
	localparam int unsigned PIN_TIE = 4;
	localparam int unsigned PIN_NUM = 5;
	// drivers off, awake, pipeline, linear, tie pin low
	localparam logic [4:0] PIN_RST = 5'h05;

	typedef enum logic {ST_IDLE, ST_BURST} ssbc_state_e;

	function automatic logic [1:0] ssbc_burst_seq(input logic [1:0] start,
		input logic [1:0] cnt, input logic linear);
		logic [1:0] sum;
		sum = start + cnt;
		return linear ? sum : (start ^ cnt);
	endfunction
endpackage

// File: logic/ssbc_lane_decode.sv
// byte lane write decode of the sram write controls
// assumes controls are already sampled in the pclk domain
`timescale 1ns/10ps
module ssbc_lane_decode #(
	parameter int unsigned LANES = 4 // lane count, 2 for the narrow part
) (
	input wire logic global_write_n, // write all lanes, low
	input wire logic byte_write_gate_n, // byte write gate, low
	input wire logic [LANES-1:0] lane_write_n, // per lane enables, low
	output logic write_cycle, // cycle is a write
	output logic [LANES-1:0] lane_we // lanes to store
);
	always_comb begin
		write_cycle = !global_write_n || !byte_write_gate_n;
		if (!global_write_n) begin
			lane_we = '1;
		end else if (!byte_write_gate_n) begin
			lane_we = ~lane_write_n;
		end else begin
			lane_we = '0;
		end
	end
endmodule

// File: logic/ssbc_burst_counter.sv
// two bit burst address counter, linear or interleaved order
// assumes load and advance never come in the same cycle
`timescale 1ns/10ps
module ssbc_burst_counter (
	input wire logic clk, // clock
	input wire logic rst_n, // async reset, low
	input wire logic load, // new external address
	input wire logic [1:0] start, // low address bits
	input wire logic advance, // step to next address
	input wire logic linear, // linear order when high
	output logic [1:0] next_low, // low bits used this cycle
	output logic [1:0] cur_low // low bits held
);
	import ssbc_pkg::*;
	logic [1:0] start_q;
	logic [1:0] cnt_q;
	logic [1:0] next_start;
	logic [1:0] next_cnt;

	always_comb begin
		next_start = load ? start : start_q;
		next_cnt = cnt_q;
		if (load) begin
			next_cnt = 2'h0;
		end else if (advance) begin
			next_cnt = cnt_q + 2'h1;
		end
		next_low = ssbc_burst_seq(next_start, next_cnt, linear);
		cur_low = ssbc_burst_seq(start_q, cnt_q, linear);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= 2'h0;
			cnt_q <= 2'h0;
		end else begin
			start_q <= next_start;
			cnt_q <= next_cnt;
		end
	end

	sequence burst4_s;
		load ##1 (advance && !load) [*4];
	endsequence

	hold_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!load && !advance) |=> $stable(cnt_q) && $stable(start_q))
		else $error("burst counter moved without advance");
	linear_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		(advance && linear) ##1 linear |-> cur_low == 2'($past(cur_low) + 2'h1))
		else $error("linear burst did not add one");
	ilv_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		(advance && !linear) ##1 !linear |->
		(cur_low ^ start_q) == 2'($past(cnt_q) + 2'h1))
		else $error("interleaved burst not start xor count");
	burst_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		burst4_s |=> cnt_q == 2'h0 && cur_low == start_q)
		else $error("burst did not wrap to start");
endmodule

// File: logic/ssbc_top.sv
// synchronous burst sram: command decode, burst counter, byte lanes, output path, apb status
// assumes the sram bus is driven from pclk; strap, sleep and output enable pins are async
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module ssbc_top #(
	parameter int unsigned ADDR_W = 20, // word address width
	parameter int unsigned LANES = 4, // byte lanes, 2 for the narrow part
	parameter int unsigned LANE_W = 9 // bits per lane with parity
) (
	input wire logic pclk, // clock, also the sram clock
	input wire logic presetn, // async reset, low
	input wire logic [ssbc_pkg::APB_AW-1:0] paddr, // apb byte address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic [ADDR_W-3:0] addr_high, // upper address bits
	input wire logic [1:0] addr_low_bits, // low address bits, counter preset
	input wire logic chip_sel1_n, // chip enable one, low
	input wire logic chip_sel2, // chip enable two, high
	input wire logic chip_sel3_n, // chip enable three, low
	input wire logic proc_addr_strobe_n, // processor address strobe, low
	input wire logic ctrl_addr_strobe_n, // controller address strobe, low
	input wire logic burst_advance_n, // burst advance, low
	input wire logic global_write_n, // write all lanes, low
	input wire logic byte_write_gate_n, // byte write gate, low
	input wire logic [LANES-1:0] lane_write_n, // lane write enables, low
	input wire logic out_enable_n, // output enable, low, async
	input wire logic sleep_req, // standby request, high, async
	input wire logic flow_through_sel_n, // flow through when low, async strap
	input wire logic linear_order_sel_n, // linear order when low, async strap
	input wire logic tie_low_pin, // must be held low
	input wire logic [LANES*LANE_W-1:0] data_in, // data pins in
	output logic [LANES*LANE_W-1:0] data_out, // data pins out
	output logic [LANES-1:0] data_oe // data pin drive per lane
);
	import ssbc_pkg::*;
	localparam int unsigned DW = LANES * LANE_W;
	localparam int unsigned DEPTH = 2 ** ADDR_W;

	logic [PIN_NUM-1:0] pin_raw;
	logic [PIN_NUM-1:0] sync_1;
	logic [PIN_NUM-1:0] sync_2;
	logic [PIN_NUM-1:0] next_sync_1;
	logic [PIN_NUM-1:0] next_sync_2;
	logic oe_off;
	logic sleeping;
	logic flow;
	logic linear;
	logic tie_seen;
	logic chip_en;
	logic ads_p;
	logic ads_c;
	logic begin_burst;
	logic desel;
	logic cont;
	logic step_en;
	logic wr_cycle;
	logic [LANES-1:0] lane_we;
	logic cycle_read;
	logic cycle_write;
	ssbc_state_e state_q;
	ssbc_state_e next_state;
	logic [ADDR_W-3:0] hi_q;
	logic [ADDR_W-3:0] next_hi;
	logic [1:0] next_low;
	logic [1:0] cur_low;
	logic [ADDR_W-1:0] eff_addr;
	logic [DW-1:0] mem [DEPTH];
	logic rd1_q;
	logic next_rd1;
	logic [DW-1:0] q1_q;
	logic [DW-1:0] next_q1;
	logic drive;
	logic [DW-1:0] next_data_out;
	logic [LANES-1:0] next_data_oe;
	logic [31:0] ctrl_q;
	logic [31:0] next_ctrl;
	logic [31:0] status;
	logic setup;
	logic hit_ctrl;
	logic hit_stat;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// async pins pass two flops before use
	assign pin_raw = {tie_low_pin, linear_order_sel_n, flow_through_sel_n,
		sleep_req, out_enable_n};

	always_comb begin
		next_sync_1 = pin_raw;
		next_sync_2 = sync_1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_1 <= PIN_RST;
			sync_2 <= PIN_RST;
		end else begin
			sync_1 <= next_sync_1;
			sync_2 <= next_sync_2;
		end
	end

	always_comb begin
		oe_off = sync_2[PIN_OE];
		sleeping = sync_2[PIN_SLEEP] || ctrl_q[CTRL_SLEEP_POS];
		flow = !sync_2[PIN_FLOW];
		linear = !sync_2[PIN_ORDER];
		tie_seen = sync_2[PIN_TIE];
	end

	ssbc_lane_decode #(
		.LANES(LANES)
	) u_lane_decode (
		.global_write_n(global_write_n),
		.byte_write_gate_n(byte_write_gate_n),
		.lane_write_n(lane_write_n),
		.write_cycle(wr_cycle),
		.lane_we(lane_we)
	);

	// command decode of the synchronous bus
	always_comb begin
		chip_en = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
		// processor strobe is ignored while chip_sel1_n is high
		ads_p = !proc_addr_strobe_n && !chip_sel1_n;
		ads_c = !ctrl_addr_strobe_n;
		begin_burst = !sleeping && (ads_p || ads_c) && chip_en;
		desel = sleeping || ((ads_p || ads_c) && !chip_en);
		cont = !sleeping && !ads_p && !ads_c && (state_q == ST_BURST);
		step_en = cont && !burst_advance_n;
		// the first cycle of a burst begun with the processor strobe is always a read
		cycle_read = (begin_burst && (ads_p || !wr_cycle)) || (cont && !wr_cycle);
		cycle_write = (begin_burst && !ads_p && wr_cycle) || (cont && wr_cycle);
	end

	always_comb begin
		next_state = state_q;
		case (state_q)
			ST_IDLE: if (begin_burst) next_state = ST_BURST;
			ST_BURST: if (desel) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
		next_hi = begin_burst ? addr_high : hi_q;
	end

	ssbc_burst_counter u_burst_counter (
		.clk(pclk),
		.rst_n(presetn),
		.load(begin_burst),
		.start(addr_low_bits),
		.advance(step_en),
		.linear(linear),
		.next_low(next_low),
		.cur_low(cur_low)
	);

	assign eff_addr = {next_hi, next_low};

	// array write, lanes stored from data_in at the command edge
	always_ff @(posedge pclk) begin
		if (cycle_write) begin
			for (int i = 0; i < LANES; i++) begin
				if (lane_we[i]) begin
					mem[eff_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// output path: flow through one edge, pipeline two edges
	always_comb begin
		next_rd1 = cycle_read;
		next_q1 = mem[eff_addr];
		if (flow) begin
			drive = cycle_read;
		end else begin
			drive = rd1_q && !desel && !cycle_write;
		end
		drive = drive && !oe_off && !sleeping && !cycle_write;
		next_data_out = flow ? mem[eff_addr] : q1_q;
		next_data_oe = {LANES{drive}};
	end

	// apb slave, one wait free access, answer registered from setup
	always_comb begin
		status = 32'h0000_0000;
		status[STAT_BURST_POS +: 2] = cur_low;
		status[STAT_PIPE_POS] = !flow;
		status[STAT_ILV_POS] = !linear;
		status[STAT_SLEEP_POS] = sleeping;
		status[STAT_ACTIVE_POS] = (state_q == ST_BURST);
		status[STAT_TIE_POS] = tie_seen;
		setup = psel && !penable;
		hit_ctrl = (paddr == CTRL_OFF);
		hit_stat = (paddr == STAT_OFF);
		next_pready = setup;
		next_pslverr = setup && !(hit_ctrl || hit_stat);
		next_prdata = 32'h0000_0000;
		if (setup && !pwrite && hit_ctrl) begin
			next_prdata = ctrl_q;
		end else if (setup && !pwrite && hit_stat) begin
			next_prdata = status;
		end
		next_ctrl = ctrl_q;
		if (psel && penable && pready && pwrite && hit_ctrl) begin
			next_ctrl = pwdata & CTRL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			hi_q <= '0;
			rd1_q <= 1'b0;
			q1_q <= '0;
			data_out <= '0;
			data_oe <= '0;
			ctrl_q <= CTRL_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			state_q <= next_state;
			hi_q <= next_hi;
			rd1_q <= next_rd1;
			q1_q <= next_q1;
			data_out <= next_data_out;
			data_oe <= next_data_oe;
			ctrl_q <= next_ctrl;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence oe_held_s;
		out_enable_n [*3];
	endsequence
	sequence pipe_read_s;
		(!flow && cycle_read) ##1 (!flow && !desel && !cycle_write && !oe_off && !sleeping);
	endsequence

	oe_release_a: assert property (oe_held_s |=> data_oe == '0)
		else $error("drivers on while output enable high");
	write_hiz_a: assert property (cycle_write |=> data_oe == '0)
		else $error("drivers on after a write cycle");
	desel_off_a: assert property (desel |=> data_oe == '0)
		else $error("drivers on after deselect");
	glob_write_a: assert property ((cycle_write && !global_write_n) |-> &lane_we)
		else $error("global write missed a lane");
	lane_pick_a: assert property ((global_write_n && !byte_write_gate_n) |->
		lane_we == ~lane_write_n)
		else $error("byte write lanes wrong");
	read_lanes_a: assert property ((cont && global_write_n && byte_write_gate_n) |->
		cycle_read && !cycle_write)
		else $error("read continuation not taken as read");
	flow_read_a: assert property ((flow && cycle_read && !oe_off && !sleeping) |=>
		&data_oe)
		else $error("flow through read not driven next cycle");
	pipe_read_a: assert property (pipe_read_s |=> &data_oe)
		else $error("pipelined read not driven on second cycle");
	sleep_idle_a: assert property (sleeping |-> !cycle_read && !cycle_write)
		else $error("command taken in standby");
	begin_load_a: assert property (begin_burst |=> cur_low == $past(addr_low_bits))
		else $error("counter not preset from address");
	step_gate_a: assert property ((state_q == ST_BURST && !sleeping && proc_addr_strobe_n
		&& ctrl_addr_strobe_n && burst_advance_n) |-> !step_en)
		else $error("counter advanced with advance high");
	apb_ready_a: assert property ((psel && !penable) |=> pready ##1 !pready)
		else $error("apb ready not a single access cycle");
endmodule

// File: tb/ssbc_bus_ctrl.sv
// far side model: a memory controller driving the synchronous sram bus
// assumes clk is the shared bus clock; every call issues one command at the next rising edge
`timescale 1ns/10ps
module ssbc_bus_ctrl (
	input wire logic clk, // bus clock
	output logic [5:0] addr_high, // upper word address
	output logic [1:0] addr_low_bits, // low address bits
	output logic chip_sel1_n, // chip enable one
	output logic chip_sel2, // chip enable two
	output logic chip_sel3_n, // chip enable three
	output logic proc_addr_strobe_n, // processor strobe
	output logic ctrl_addr_strobe_n, // controller strobe
	output logic burst_advance_n, // burst advance
	output logic global_write_n, // write all lanes
	output logic byte_write_gate_n, // byte write gate
	output logic [3:0] lane_write_n, // lane enables
	output logic tie_low_pin, // held low
	output logic [35:0] data_in // write data
);
	initial begin
		addr_high = 6'h15;
		addr_low_bits = 2'h0;
		{chip_sel3_n, chip_sel2, chip_sel1_n} = 3'h2;
		proc_addr_strobe_n = 1'b1;
		ctrl_addr_strobe_n = 1'b1;
		burst_advance_n = 1'b1;
		global_write_n = 1'b1;
		byte_write_gate_n = 1'b1;
		lane_write_n = 4'hf;
		tie_low_pin = 1'b0;
		data_in = 36'h0;
	end

	// kinds: 0 suspend, 1 advance, 2 ctrl begin, 3 proc begin, 4..6 one enable false
	task automatic op(input int unsigned k, input logic [1:0] w, input logic [3:0] ln,
		input logic [1:0] a, input logic [35:0] d);
		@(posedge clk);
		proc_addr_strobe_n <= (k != 3);
		ctrl_addr_strobe_n <= !(k == 2 || k >= 4);
		burst_advance_n <= (k != 1);
		{chip_sel3_n, chip_sel2, chip_sel1_n} <= (k >= 4) ? 3'h2 ^ (3'h1 << (k - 4)) : 3'h2;
		global_write_n <= w[1];
		byte_write_gate_n <= w[0];
		lane_write_n <= ln;
		addr_low_bits <= a;
		// released data line shows no stale value
		data_in <= (w != 2'h3) ? d : ~data_in;
	endtask
endmodule

// File: tb/sync_burst_sram_control_tb.sv
// testbench: apb status access plus sram bus bursts through the controller model
// assumes ssbc_top with ADDR_W 8 and four lanes of nine bits
`timescale 1ns/10ps
module sync_burst_sram_control_tb;
	import ssbc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] addr_high;
	logic [1:0] addr_low_bits;
	logic chip_sel1_n, chip_sel2, chip_sel3_n, proc_addr_strobe_n, ctrl_addr_strobe_n;
	logic burst_advance_n, global_write_n, byte_write_gate_n, tie_low_pin;
	logic out_enable_n, sleep_req, flow_through_sel_n, linear_order_sel_n;
	logic [3:0] lane_write_n, data_oe;
	logic [35:0] data_in, data_out;
	logic [35:0] mem [4];
	int bad_count, checked;

	ssbc_top #(.ADDR_W(8)) i_ssbc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .addr_high(addr_high),
		.addr_low_bits(addr_low_bits), .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2),
		.chip_sel3_n(chip_sel3_n), .proc_addr_strobe_n(proc_addr_strobe_n),
		.ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_advance_n(burst_advance_n),
		.global_write_n(global_write_n), .byte_write_gate_n(byte_write_gate_n),
		.lane_write_n(lane_write_n), .out_enable_n(out_enable_n), .sleep_req(sleep_req),
		.flow_through_sel_n(flow_through_sel_n), .linear_order_sel_n(linear_order_sel_n),
		.tie_low_pin(tie_low_pin), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

	ssbc_bus_ctrl i_ssbc_bus_ctrl (.clk(pclk), .addr_high(addr_high),
		.addr_low_bits(addr_low_bits), .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2),
		.chip_sel3_n(chip_sel3_n), .proc_addr_strobe_n(proc_addr_strobe_n),
		.ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_advance_n(burst_advance_n),
		.global_write_n(global_write_n), .byte_write_gate_n(byte_write_gate_n),
		.lane_write_n(lane_write_n), .tie_low_pin(tie_low_pin), .data_in(data_in));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic finish_test;
		if (bad_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// begin, four advances (fourth wraps), two suspends, then deselect
	task automatic burst(input int unsigned k0, input logic [1:0] s, input logic lin,
		input int lat);
		logic [1:0] e;
		for (int i = 0; i < 8; i++) begin
			i_ssbc_bus_ctrl.op(i == 0 ? k0 : (i < 5 ? 1 : (i < 7 ? 0 : 4)), 2'h3, 4'h0, s, '0);
			@(negedge pclk);
			if (i >= lat && i - lat < 6) begin
				e = (i - lat >= 4) ? s : (lin ? s + 2'(i - lat) : s ^ 2'(i - lat));
				chk(data_out, mem[e]);
				chk(36'(data_oe), 36'hf);
			end
		end
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		out_enable_n = 1'b0;
		sleep_req = 1'b0;
		flow_through_sel_n = 1'b1;
		linear_order_sel_n = 1'b0;
		bad_count = 0;
		checked = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, STAT_OFF, 32'h0);
		chk(36'(rd[6:2]), 36'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk(36'(err), 36'h1);
		apb(1'b1, CTRL_OFF, 32'hffff_ffff);
		apb(1'b0, CTRL_OFF, 32'h0);
		chk(36'(rd), 36'(CTRL_MASK));
		apb(1'b0, STAT_OFF, 32'h0);
		chk(36'(rd[STAT_SLEEP_POS]), 36'h1);
		apb(1'b1, CTRL_OFF, 32'h0);
		for (int k = 0; k < 4; k++) begin
			mem[k] = 36'h1_2345_6789 * 36'(k + 1);
			i_ssbc_bus_ctrl.op(2, 2'h0, 4'hf, 2'(k), mem[k]);
			@(negedge pclk);
			chk(36'(data_oe), 36'h0);
		end
		i_ssbc_bus_ctrl.op(2, 2'h2, 4'b1010, 2'h1, 36'hf_ffff_ffff);
		mem[1][8:0] = 9'h1ff;
		mem[1][26:18] = 9'h1ff;
		i_ssbc_bus_ctrl.op(2, 2'h2, 4'hf, 2'h2, 36'hf_ffff_ffff);
		i_ssbc_bus_ctrl.op(0, 2'h3, 4'h0, 2'h0, '0);
		burst(2, 2'h2, 1'b1, 2);
		@(posedge pclk);
		flow_through_sel_n <= 1'b0;
		linear_order_sel_n <= 1'b1;
		repeat (4) @(posedge pclk);
		burst(3, 2'h3, 1'b0, 1);
		@(posedge pclk);
		out_enable_n <= 1'b1;
		repeat (4) @(posedge pclk);
		i_ssbc_bus_ctrl.op(2, 2'h3, 4'h0, 2'h1, '0);
		for (int k = 0; k < 3; k++) begin
			i_ssbc_bus_ctrl.op(1, 2'h3, 4'h0, 2'h1, '0);
			@(negedge pclk);
			chk(36'(data_oe), 36'h0);
		end
		i_ssbc_bus_ctrl.op(0, 2'h3, 4'h0, 2'h1, '0);
		apb(1'b0, STAT_OFF, 32'h0);
		chk(36'(rd[3:0]), 36'ha);
		out_enable_n <= 1'b0;
		sleep_req <= 1'b1;
		repeat (4) @(posedge pclk);
		i_ssbc_bus_ctrl.op(2, 2'h3, 4'h0, 2'h0, '0);
		i_ssbc_bus_ctrl.op(0, 2'h3, 4'h0, 2'h0, '0);
		@(negedge pclk);
		chk(36'(data_oe), 36'h0);
		@(posedge pclk);
		sleep_req <= 1'b0;
		repeat (4) @(posedge pclk);
		for (int k = 4; k < 7; k++) begin
			i_ssbc_bus_ctrl.op(k, 2'h3, 4'h0, 2'h0, '0);
			i_ssbc_bus_ctrl.op(0, 2'h3, 4'h0, 2'h0, '0);
			@(negedge pclk);
			chk(36'(data_oe), 36'h0);
		end
		finish_test();
	end

	initial begin
		#100000;
		bad_count++;
		finish_test();
	end
endmodule
